// file: design/rtp_rmii_port.sv
// Purpose: reduced media-independent port on the switch's third MAC, link-facing logic
// Assumes: partner pins change on the shared reference clock, which runs free
// Notes:   errored or collided frames are marked bad on their last byte for the switch to drop
// Behaviour
// - port attaches to third MAC, signalling follows the standard reduced interface
// - receive, transmit and control all timed by one shared 50 MHz reference
// - separate two-bit transmit and receive paths, each its own signal group
// - port runs at 10 or 100 Mbps over the same dibit interface
// - errored frames discarded internally; no receive-error output toward partner
// - PHY receive-error drives our transmit-error input, flagging errored incoming frames
// - collisions detected as the reduced interface defines, no collision pin
// - port works with either a PHY or a MAC partner
// - back-to-back: our valid and data outputs feed partner's valid and data inputs
`timescale 1ns/100ps
module rtp_rmii_port
  import rtp_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic               SPEED_100,
  input  wire logic               HALF_DUPLEX,
  input  wire logic               EG_VALID,
  output logic                    EG_READY,
  input  wire logic [BYTE_W-1:0]  EG_DATA,
  input  wire logic               EG_LAST,
  output logic                    IN_VALID,
  output logic [BYTE_W-1:0]       IN_DATA,
  output logic                    IN_LAST,
  output logic                    IN_BAD,
  output logic                    COLLISION,
  input  wire logic               PORT3_REF_CLOCK_IN,
  input  wire logic               PORT3_TX_ENABLE_IN,
  input  wire logic               PORT3_TX_DATA_BIT1,
  input  wire logic               PORT3_TX_DATA_BIT0,
  input  wire logic               PORT3_TX_ERROR_IN,
  output logic                    PORT3_RX_VALID_OUT,
  output logic                    PORT3_RX_DATA_BIT1,
  output logic                    PORT3_RX_DATA_BIT0
);
  // ---- system-clock side: two-entry egress buffer
  logic [EG_WORD_W-1:0] eb_mem [2];
  logic                 eb_wp;
  logic                 eb_rp;
  logic [1:0]           eb_cnt;
  logic                 eb_push;
  logic                 eb_pop;
  logic                 eg_wr_ready;
  logic                 in_rd_valid;
  logic [IN_WORD_W-1:0] in_rd_data;
  logic                 col_c1;
  logic                 col_c2;
  // ---- link side
  logic                 lrst_s1;
  logic                 lrst;
  logic                 spd_s1;
  logic                 spd;
  logic                 half_s1;
  logic                 half;
  logic                 en_s1;
  logic                 en_s;
  logic [1:0]           d_s1;
  logic [1:0]           d_s;
  logic                 er_s1;
  logic                 er_s;
  logic                 en_d;
  logic [3:0]           div;
  logic                 tick;
  rtp_tx_e              tx_st;
  logic [5:0]           tx_cnt;
  logic [BYTE_W-1:0]    tx_sh;
  logic [1:0]           tx_dib;
  logic                 tx_last;
  logic                 crs_out;
  logic [1:0]           rxd_out;
  logic                 eg_rd_valid;
  logic                 eg_rd_ready;
  logic [EG_WORD_W-1:0] eg_rd_data;
  rtp_rx_e              rx_st;
  logic [3:0]           rx_div;
  logic                 strobe;
  logic [BYTE_W-1:0]    rx_sh;
  logic [BYTE_W-1:0]    next_byte;
  logic [BYTE_W-1:0]    rx_pend;
  logic [1:0]           rx_dib;
  logic                 rx_have;
  logic                 rx_bad;
  logic                 col_l;
  logic                 push_v;
  logic [IN_WORD_W-1:0] push_w;

  assign EG_READY = eb_cnt != EB_FULL;
  assign eb_push  = EG_VALID && EG_READY;
  assign eb_pop   = (eb_cnt != EB_EMPTY) && eg_wr_ready;

  always_ff @(posedge CLK) begin
    if (eb_push) begin
      eb_mem[eb_wp] <= {EG_LAST, EG_DATA};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      eb_wp  <= 1'b0;
      eb_rp  <= 1'b0;
      eb_cnt <= EB_EMPTY;
    end else begin
      eb_wp  <= eb_wp ^ eb_push;
      eb_rp  <= eb_rp ^ eb_pop;
      eb_cnt <= eb_cnt + 2'(eb_push) - 2'(eb_pop);
    end
  end

  // ingress words are drained every cycle; 20 MHz outpaces the 12.5 Mbyte/s link
  always_ff @(posedge CLK) begin
    if (RST) begin
      IN_VALID <= 1'b0;
      IN_DATA  <= '0;
      IN_LAST  <= 1'b0;
      IN_BAD   <= 1'b0;
    end else begin
      IN_VALID <= in_rd_valid;
      IN_DATA  <= in_rd_data[BYTE_W-1:0];
      IN_LAST  <= in_rd_valid && in_rd_data[IN_WORD_W-1];
      IN_BAD   <= in_rd_valid && in_rd_data[IN_WORD_W-2];
    end
  end

  always_ff @(posedge CLK) begin
    col_c1    <= col_l;
    col_c2    <= col_c1;
    COLLISION <= col_c2 && !RST;
  end

  rtp_afifo #(.W(EG_WORD_W), .AW(FIFO_AW)) u_eg_fifo (
    .wr_clk   (CLK),
    .wr_rst   (RST),
    .wr_valid (eb_cnt != EB_EMPTY),
    .wr_ready (eg_wr_ready),
    .wr_data  (eb_mem[eb_rp]),
    .rd_clk   (PORT3_REF_CLOCK_IN),
    .rd_rst   (lrst),
    .rd_valid (eg_rd_valid),
    .rd_ready (eg_rd_ready),
    .rd_data  (eg_rd_data)
  );

  rtp_afifo #(.W(IN_WORD_W), .AW(FIFO_AW)) u_in_fifo (
    .wr_clk   (PORT3_REF_CLOCK_IN),
    .wr_rst   (lrst),
    .wr_valid (push_v),
    .wr_ready (),
    .wr_data  (push_w),
    .rd_clk   (CLK),
    .rd_rst   (RST),
    .rd_valid (in_rd_valid),
    .rd_ready (1'b1),
    .rd_data  (in_rd_data)
  );

  // ---- link domain: everything below runs on the shared reference
  always_ff @(posedge PORT3_REF_CLOCK_IN) begin
    lrst_s1 <= RST;
    lrst    <= lrst_s1;
    spd_s1  <= SPEED_100;
    spd     <= spd_s1;
    half_s1 <= HALF_DUPLEX;
    half    <= half_s1;
    en_s1   <= PORT3_TX_ENABLE_IN;
    en_s    <= en_s1;
    d_s1    <= {PORT3_TX_DATA_BIT1, PORT3_TX_DATA_BIT0};
    d_s     <= d_s1;
    er_s1   <= PORT3_TX_ERROR_IN;
    er_s    <= er_s1;
    en_d    <= en_s;
  end

  assign tick = spd || (div == SLOW_DIV_LAST);

  always_ff @(posedge PORT3_REF_CLOCK_IN) begin
    if (lrst || div == SLOW_DIV_LAST) begin
      div <= '0;
    end else begin
      div <= div + 4'h1;
    end
  end

  // a frame cut short by an empty fifo ends early; remaining bytes start a new frame
  assign eg_rd_ready = tick && ((tx_st == TX_PRE && tx_cnt == PRE_LAST) ||
                                (tx_st == TX_DATA && tx_dib == DIBIT_LAST && !tx_last));

  always_ff @(posedge PORT3_REF_CLOCK_IN) begin
    if (lrst) begin
      tx_st   <= TX_IDLE;
      tx_cnt  <= '0;
      tx_sh   <= '0;
      tx_dib  <= '0;
      tx_last <= 1'b0;
      crs_out <= 1'b0;
      rxd_out <= DIBIT_IDLE;
    end else if (tick) begin
      unique case (tx_st)
        TX_IDLE: begin
          crs_out <= 1'b0;
          rxd_out <= DIBIT_IDLE;
          tx_cnt  <= '0;
          if (eg_rd_valid) begin
            tx_st <= TX_PRE;
          end
        end
        TX_PRE: begin
          crs_out <= 1'b1;
          rxd_out <= (tx_cnt == PRE_LAST) ? DIBIT_SFD : DIBIT_PRE;
          tx_cnt  <= tx_cnt + 6'h01;
          if (tx_cnt == PRE_LAST) begin
            tx_st   <= TX_DATA;
            tx_sh   <= eg_rd_data[BYTE_W-1:0];
            tx_last <= eg_rd_data[EG_WORD_W-1];
            tx_dib  <= '0;
          end
        end
        TX_DATA: begin
          crs_out <= 1'b1;
          rxd_out <= tx_sh[1:0];
          tx_sh   <= {2'h0, tx_sh[BYTE_W-1:2]};
          tx_dib  <= tx_dib + 2'h1;
          if (tx_dib == DIBIT_LAST) begin
            if (!tx_last && eg_rd_valid) begin
              tx_sh   <= eg_rd_data[BYTE_W-1:0];
              tx_last <= eg_rd_data[EG_WORD_W-1];
            end else begin
              tx_st  <= TX_GAP;
              tx_cnt <= '0;
            end
          end
        end
        TX_GAP: begin
          crs_out <= 1'b0;
          rxd_out <= DIBIT_IDLE;
          tx_cnt  <= tx_cnt + 6'h01;
          if (tx_cnt == GAP_LAST) begin
            tx_st <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // same pins whether the partner is a PHY or a MAC wired back to back
  assign PORT3_RX_VALID_OUT = crs_out;
  assign PORT3_RX_DATA_BIT1 = rxd_out[1];
  assign PORT3_RX_DATA_BIT0 = rxd_out[0];

  // half duplex: partner carrier while we send is a collision
  always_ff @(posedge PORT3_REF_CLOCK_IN) begin
    if (lrst) begin
      col_l <= 1'b0;
    end else begin
      col_l <= half && crs_out && en_s;
    end
  end

  always_ff @(posedge PORT3_REF_CLOCK_IN) begin
    if (lrst || (en_s && !en_d) || rx_div == SLOW_DIV_LAST) begin
      rx_div <= '0;
    end else begin
      rx_div <= rx_div + 4'h1;
    end
  end

  assign strobe    = en_s && (spd || rx_div == SLOW_SAMPLE);
  assign next_byte = {d_s, rx_sh[BYTE_W-1:2]};

  // one byte is held back so the frame's end can mark it last and good or bad
  always_ff @(posedge PORT3_REF_CLOCK_IN) begin
    if (lrst) begin
      rx_st   <= RX_HUNT;
      rx_sh   <= '0;
      rx_pend <= '0;
      rx_dib  <= '0;
      rx_have <= 1'b0;
      rx_bad  <= 1'b0;
      push_v  <= 1'b0;
      push_w  <= '0;
    end else begin
      push_v <= 1'b0;
      if (!en_s) begin
        if (rx_st == RX_DATA && rx_have) begin
          push_v <= 1'b1;
          push_w <= {1'b1, rx_bad || rx_dib != 2'h0, rx_pend};
        end
        rx_st   <= RX_HUNT;
        rx_have <= 1'b0;
        rx_bad  <= 1'b0;
        rx_dib  <= '0;
      end else begin
        if (er_s || col_l) begin
          rx_bad <= 1'b1;
        end
        if (strobe) begin
          unique case (rx_st)
            RX_HUNT: begin
              rx_dib <= '0;
              if (d_s == DIBIT_SFD) begin
                rx_st <= RX_DATA;
              end
            end
            RX_DATA: begin
              rx_sh  <= next_byte;
              rx_dib <= rx_dib + 2'h1;
              if (rx_dib == DIBIT_LAST) begin
                rx_pend <= next_byte;
                rx_have <= 1'b1;
                if (rx_have) begin
                  push_v <= 1'b1;
                  push_w <= {2'b00, rx_pend};
                end
              end
            end
          endcase
        end
      end
    end
  end

  // ---- assertions
  sequence s_pre_tick;
    tx_st == TX_PRE && tick && tx_cnt != PRE_LAST;
  endsequence
  sequence s_sfd_tick;
    tx_st == TX_PRE && tick && tx_cnt == PRE_LAST;
  endsequence

  a_pre_pattern: assert property (@(posedge PORT3_REF_CLOCK_IN) disable iff (lrst)
    s_pre_tick |=> crs_out && rxd_out == DIBIT_PRE) else $error("preamble dibit wrong");
  a_sfd_to_data: assert property (@(posedge PORT3_REF_CLOCK_IN) disable iff (lrst)
    s_sfd_tick |=> rxd_out == DIBIT_SFD && tx_st == TX_DATA) else $error("delimiter not sent");
  a_lsb_first: assert property (@(posedge PORT3_REF_CLOCK_IN) disable iff (lrst)
    tx_st == TX_DATA && tick |=> rxd_out == $past(tx_sh[1:0])) else $error("dibit order wrong");
  a_slow_hold: assert property (@(posedge PORT3_REF_CLOCK_IN) disable iff (lrst)
    !spd && $changed(rxd_out) |-> $past(div) == SLOW_DIV_LAST) else $error("10M dibit not held");
  a_link_reset: assert property (@(posedge PORT3_REF_CLOCK_IN)
    lrst |=> tx_st == TX_IDLE && !crs_out && !push_v) else $error("link side not reset");
  a_error_marks: assert property (@(posedge PORT3_REF_CLOCK_IN) disable iff (lrst)
    en_s && er_s ##1 en_s |-> rx_bad) else $error("receive error not flagged");
  a_collide_flag: assert property (@(posedge PORT3_REF_CLOCK_IN) disable iff (lrst)
    half && crs_out && en_s |=> col_l ##1 rx_bad || !en_s) else $error("collision missed");
  a_frame_close: assert property (@(posedge PORT3_REF_CLOCK_IN) disable iff (lrst)
    rx_st == RX_DATA && rx_have && !en_s |=> push_v && push_w[IN_WORD_W-1]) else $error("frame end lost");
  a_fast_byte: assert property (@(posedge PORT3_REF_CLOCK_IN) disable iff (lrst)
    rx_st == RX_DATA && strobe && spd && rx_dib == DIBIT_LAST |=> rx_have) else $error("byte not taken");
  a_buffer_full: assert property (@(posedge CLK) disable iff (RST)
    eb_cnt == EB_FULL |-> !EG_READY ##1 eb_cnt != EB_EMPTY) else $error("egress buffer overrun");
endmodule

// file: common/rtp_pkg.sv
// Purpose: shared constants and state types for the port-three reduced interface
// Assumes: 50 MHz link reference, 20 MHz system clock
// Notes:   dibits travel least significant pair first
package rtp_pkg;
  localparam int          SYS_CLK_MHZ     = 20;
  localparam int          REF_CLK_MHZ     = 50;
  localparam int          DIBIT_W         = 2;
  localparam int          BYTE_W          = 8;
  localparam int          EG_WORD_W       = 9;     // {last, byte}
  localparam int          IN_WORD_W       = 10;    // {last, bad, byte}
  localparam int          FIFO_AW         = 2;     // four words per crossing fifo
  localparam logic [3:0]  SLOW_DIV_LAST   = 4'h9;  // 10 Mbps: each dibit held ten reference cycles
  localparam logic [3:0]  SLOW_SAMPLE     = 4'h5;  // mid-dibit sample point at 10 Mbps
  localparam logic [5:0]  PRE_LAST        = 6'h1F; // 32 dibits of preamble and delimiter
  localparam logic [5:0]  GAP_LAST        = 6'h2F; // 48 idle dibits between frames
  localparam logic [1:0]  DIBIT_PRE       = 2'h1;
  localparam logic [1:0]  DIBIT_SFD       = 2'h3;
  localparam logic [1:0]  DIBIT_IDLE      = 2'h0;
  localparam logic [1:0]  DIBIT_LAST      = 2'h3;
  localparam logic [1:0]  EB_FULL         = 2'h2;
  localparam logic [1:0]  EB_EMPTY        = 2'h0;

  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_GAP} rtp_tx_e;
  typedef enum logic {RX_HUNT, RX_DATA} rtp_rx_e;
endpackage

// file: design/rtp_afifo.sv
// Purpose: dual-clock fifo with gray-coded pointers and valid/ready on both sides
// Assumes: AW of at least 2; each side has its own synchronous reset
// Notes:   read data is the head word, valid while rd_valid is high
`timescale 1ns/100ps
module rtp_afifo #(
  parameter int W  = 8,
  parameter int AW = 2
) (
  input  wire logic          wr_clk,
  input  wire logic          wr_rst,
  input  wire logic          wr_valid,
  output logic               wr_ready,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_clk,
  input  wire logic          rd_rst,
  output logic               rd_valid,
  input  wire logic          rd_ready,
  output logic [W-1:0]       rd_data
);
  logic [W-1:0] mem [2**AW];
  logic [AW:0]  wbin;
  logic [AW:0]  wgray;
  logic [AW:0]  rbin;
  logic [AW:0]  rgray;
  logic [AW:0]  rg_s1;
  logic [AW:0]  rg_s2;
  logic [AW:0]  wg_s1;
  logic [AW:0]  wg_s2;
  logic [AW:0]  next_wbin;
  logic [AW:0]  next_rbin;
  logic         push;
  logic         pop;

  assign push      = wr_valid && wr_ready;
  assign pop       = rd_valid && rd_ready;
  assign next_wbin = wbin + (AW+1)'(push);
  assign next_rbin = rbin + (AW+1)'(pop);
  assign wr_ready  = wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]};
  assign rd_valid  = rgray != wg_s2;
  assign rd_data   = mem[rbin[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin[AW-1:0]] <= wr_data;
    end
  end

  // gray code is registered so the far side never sees a multi-bit glitch
  always_ff @(posedge wr_clk) begin
    if (wr_rst) begin
      wbin  <= '0;
      wgray <= '0;
    end else begin
      wbin  <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
    end
  end

  always_ff @(posedge wr_clk) begin
    rg_s1 <= rgray;
    rg_s2 <= rg_s1;
  end

  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin  <= '0;
      rgray <= '0;
    end else begin
      rbin  <= next_rbin;
      rgray <= next_rbin ^ (next_rbin >> 1);
    end
  end

  always_ff @(posedge rd_clk) begin
    wg_s1 <= wgray;
    wg_s2 <= wg_s1;
  end
endmodule

// file: sim/rtp_partner.sv
// Purpose: far-side partner on the reduced interface: sends frames, decodes ours
// Assumes: shared reference clock runs free
// Notes:   idle data lines toggle so a stale value is never trusted
`timescale 1ns/100ps
module rtp_partner (
  input  wire logic ref_clk,
  input  wire logic speed100,
  input  wire logic rx_dv,
  input  wire logic rx_d1,
  input  wire logic rx_d0,
  output logic      tx_en,
  output logic      tx_d1,
  output logic      tx_d0,
  output logic      tx_er
);
  // our valid and data inputs face the device's valid and data outputs; no upper strap pins exist
  logic       busy = 0;
  logic       idle_pat = 0;
  logic [1:0] drv = 2'h0;
  logic [1:0] dib;
  logic [3:0] ph = 4'h0;
  logic       indata = 0;
  logic [1:0] nb = 2'h0;
  logic [7:0] sr = 8'h00;
  logic       dv_q = 0;
  int         pre = 0;
  int         pre_bad = 0;
  int         frames = 0;
  int         gap = 0;
  int         gap_min = 99999;
  int         idle_bad = 0;
  logic [7:0] got[$];

  assign dib = {rx_d1, rx_d0};
  assign tx_d1 = busy ? drv[1] : idle_pat;
  assign tx_d0 = busy ? drv[0] : ~idle_pat;

  initial begin
    tx_en = 0;
    tx_er = 0;
  end

  always @(posedge ref_clk) idle_pat <= ~idle_pat;

  // mid-dibit sampling at 10 Mbps keeps clear of the edges
  always @(posedge ref_clk) begin
    dv_q <= rx_dv;
    ph <= (!rx_dv || ph == 4'h9) ? 4'h0 : ph + 4'h1;
    if (!rx_dv) begin
      gap <= gap + 1;
      pre <= 0;
      indata <= 0;
      if (dib !== 2'h0) idle_bad <= idle_bad + 1;
      if (dv_q) frames <= frames + 1;
    end else begin
      if (!dv_q && frames > 0 && gap < gap_min) gap_min <= gap;
      gap <= 0;
      if (speed100 || ph == 4'h4) begin
        if (indata) begin
          sr <= {dib, sr[7:2]};
          nb <= nb + 2'h1;
          if (nb == 2'h3) got.push_back({dib, sr[7:2]});
        end else if (dib == 2'h3) begin
          indata <= 1;
          nb <= 2'h0;
          if (pre != 31) pre_bad <= pre_bad + 1;
        end else if (dib == 2'h1) begin
          pre <= pre + 1;
        end else begin
          pre_bad <= pre_bad + 1;
        end
      end
    end
  end

  task automatic clear();
    got.delete();
    frames = 0;
    gap_min = 99999;
    pre_bad = 0;
    idle_bad = 0;
  endtask

  task automatic send(input logic [7:0] b[$], input logic err);
    int hold;
    int k;
    hold = speed100 ? 1 : 10;
    @(posedge ref_clk);
    busy <= 1;
    tx_en <= 1;
    for (int i = 0; i < 32 + 4 * b.size(); i++) begin
      k = i - 32;
      drv <= i < 31 ? 2'h1 : i == 31 ? 2'h3 : b[k / 4][2 * (k % 4) +: 2];
      tx_er <= err && i == 32 + 2 * b.size();
      repeat (hold) @(posedge ref_clk);
    end
    tx_en <= 0;
    busy <= 0;
    tx_er <= 0;
    repeat (4 * hold) @(posedge ref_clk);
  endtask
endmodule

// file: sim/rtp_rmii_port_bench.sv
// Purpose: self-checking bench for the port-three reduced interface
// Assumes: partner model on the link pins; 50 ns system and 12 ns reference clocks
// Notes:   both directions run at once in every case; seeded stimulus repeats
`timescale 1ns/100ps
module rtp_rmii_port_bench
  import rtp_pkg::*;
;
  logic              clk = 0;
  logic              rst = 1;
  logic              ref_clk = 0;
  logic              speed = 1;
  logic              half = 0;
  logic              eg_valid = 0;
  logic              eg_last = 0;
  logic [BYTE_W-1:0] eg_data = 8'h00;
  logic              eg_ready;
  logic              in_valid;
  logic [BYTE_W-1:0] in_data;
  logic              in_last;
  logic              in_bad;
  logic              collision;
  logic              tx_en;
  logic              tx_d1;
  logic              tx_d0;
  logic              tx_er;
  logic              rx_dv;
  logic              rx_d1;
  logic              rx_d0;
  logic              coll_seen = 0;
  logic              full_seen = 0;
  logic [9:0]        in_q[$];
  int                errors = 0;
  int                checks = 0;
  int                cyc = 0;

  rtp_rmii_port dut (.CLK(clk), .RST(rst), .SPEED_100(speed), .HALF_DUPLEX(half),
    .EG_VALID(eg_valid), .EG_READY(eg_ready), .EG_DATA(eg_data), .EG_LAST(eg_last),
    .IN_VALID(in_valid), .IN_DATA(in_data), .IN_LAST(in_last), .IN_BAD(in_bad),
    .COLLISION(collision), .PORT3_REF_CLOCK_IN(ref_clk), .PORT3_TX_ENABLE_IN(tx_en),
    .PORT3_TX_DATA_BIT1(tx_d1), .PORT3_TX_DATA_BIT0(tx_d0), .PORT3_TX_ERROR_IN(tx_er),
    .PORT3_RX_VALID_OUT(rx_dv), .PORT3_RX_DATA_BIT1(rx_d1), .PORT3_RX_DATA_BIT0(rx_d0));

  rtp_partner partner (.ref_clk(ref_clk), .speed100(speed), .rx_dv(rx_dv), .rx_d1(rx_d1),
    .rx_d0(rx_d0), .tx_en(tx_en), .tx_d1(tx_d1), .tx_d0(tx_d0), .tx_er(tx_er));

  initial begin
    forever #25 clk = ~clk;
  end

  // odd offset keeps the reference edges clear of the system edges
  initial begin
    #2.7;
    forever #6 ref_clk = ~ref_clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (in_valid === 1'b1) in_q.push_back({in_bad, in_last, in_data});
    if (collision === 1'b1) coll_seen <= 1;
    if (eg_ready === 1'b0) full_seen <= 1;
    if (cyc == 40000) begin
      errors++;
      stop_test();
    end
  end

  function automatic int gap_need(input logic s);
    return (int'(GAP_LAST) + 1) * (s ? 1 : 10);
  endfunction

  function automatic logic [9:0] in_exp(input logic [7:0] b, input logic last, input logic bad);
    return {bad && last, last, b};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ready only moves on rising edges, so it is settled at the falling edge
  task automatic eg_frame(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge clk);
      eg_valid = 1;
      eg_data = b[i];
      eg_last = i == b.size() - 1;
      while (eg_ready !== 1'b1) @(negedge clk);
    end
    @(negedge clk);
    eg_valid = 0;
  endtask

  task automatic run(input logic s, input logic h, input logic err);
    logic [7:0] e[$];
    logic [7:0] f[$];
    logic [7:0] ib[$];
    logic [7:0] all[$];
    int n;
    @(negedge clk);
    speed = s;
    half = h;
    repeat (20) @(negedge clk);
    partner.clear();
    in_q.delete();
    coll_seen = 0;
    full_seen = 0;
    // the bench reference is faster than 50 MHz, so at 100M a long frame would outrun the 20 MHz feed
    // through the four-word crossing and end early; seven bytes keep the fifo ahead of the link
    n = s ? 6 + $urandom % 2 : 6 + $urandom % 7;
    for (int i = 0; i < n; i++) begin
      e.push_back(i == 0 ? 8'hFF : 8'($urandom));
      f.push_back(i == 0 ? 8'h00 : 8'($urandom));
      ib.push_back(i == n - 1 ? 8'hD5 : 8'($urandom));
    end
    fork
      begin
        eg_frame(e);
        eg_frame(f);
      end
      partner.send(ib, err);
    join
    for (n = 0; n < 20000 && partner.frames < 2; n++) @(negedge clk);
    repeat (30) @(negedge clk);
    all = {e, f};
    check("frames", partner.frames, 2);
    check("eg_count", partner.got.size(), all.size());
    foreach (all[i]) check("eg_byte", partner.got[i], all[i]);
    check("preamble", partner.pre_bad, 0);
    check("idle_low", partner.idle_bad, 0);
    check("gap", partner.gap_min >= gap_need(s), 1);
    check("in_count", in_q.size(), ib.size());
    foreach (ib[i]) check("in_word", in_q[i], in_exp(ib[i], i == ib.size() - 1, err | h));
    check("collision", coll_seen, h);
    check("eg_full", full_seen, 1);
    check("eg_drained", eg_ready, 1);
    $display("test speed100=%0b half=%0b err=%0b done", s, h, err);
  endtask

  initial begin
    void'($urandom(29));
    repeat (6) @(negedge clk);
    rst = 0;
    repeat (10) @(negedge clk);
    run(1, 0, 0);
    run(0, 0, 0);
    run(1, 0, 1);
    run(1, 1, 0);
    run(0, 1, 1);
    stop_test();
  end
endmodule
